// *** rtl/cdd_cfg_if.sv ***
/*
 interface between the control top and its divider and delay-map modules.
 assumes all ends share clk.
*/
`timescale 1ns/10ps
interface cdd_cfg_if;
    import cdd_pkg::*;
    logic [1:0] ratioCode;            // divider ratio code
    logic [2:0] syncState;            // state loaded on sysref
    logic [NCH-1:0] halfDelay;        // per-channel half-period delay
    logic sysrefHit;                  // one-cycle sysref event
    logic [2:0] ctrl;                 // delay control field
    cdd_byte_t fineVal [NCH];         // raw fine codes
    cdd_byte_t superVal [NCH];        // raw super-fine codes
    logic [2:0] divCnt;               // divider position
    logic [NCH-1:0] divOut;           // divided clock per channel
    logic [NCH-1:0] sampleEn;         // one pulse per divided period
    cdd_byte_t fineOut [NCH];         // applied fine delay
    cdd_byte_t superOut [NCH];        // applied super-fine delay
    logic fineEn;                     // fine delay active
    logic superEn;                    // super-fine delay active
    logic mode192;                    // 192-step option
    modport ctl (output ratioCode, syncState, halfDelay, sysrefHit, ctrl, fineVal,
        superVal, input divCnt, divOut, sampleEn, fineOut, superOut, fineEn, superEn,
        mode192);
    modport div (input ratioCode, syncState, halfDelay, sysrefHit,
        output divCnt, divOut, sampleEn);
    modport dly (input ctrl, fineVal, superVal,
        output fineOut, superOut, fineEn, superEn, mode192);
endinterface

// *** rtl/cdd_clock_ctrl.sv ***
/*
 sample clock divider and delay control top: register file, sysref event
 capture, datapath reset request and the divider and delay submodules.
 assumes the register port is driven synchronously to clk by the serial
 configuration front end, and clk ticks once per half input clock period.
*/
//
// Operation
// - divide input clock by 1, 2 or 4
// - valid sysref loads programmable divider state
// - per-channel half-period divider phase delay
// - half-period delay write keeps link intact
// - control field picks fine or fine+super-fine
// - fine delay has 16 or 192 steps
// - super-fine unsigned, 0.25 ps per step
// - eight-bit fine value, per channel, 192 steps
// - eight-bit super-fine value, per channel, 128 steps
// - super-fine only with control 0x2 or 0x6
// - delay settings apply right after the write
// - enabling fine delay resets the datapath
// - delay value rewrites cause no reset
// - stabilizer enabled after reset, host may set
// - divider output has 50% duty cycle
`timescale 1ns/10ps
module cdd_clock_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic sysrefIn,
    input wire logic [cdd_pkg::NCH-1:0] chanSel,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire cdd_pkg::cdd_addr_t regAddr,
    input wire cdd_pkg::cdd_byte_t regWrData,
    output cdd_pkg::cdd_byte_t regRdData,
    output logic [cdd_pkg::NCH-1:0] divClkOut,
    output logic [cdd_pkg::NCH-1:0] sampleEn,
    output cdd_pkg::cdd_byte_t fineDelay [cdd_pkg::NCH],
    output cdd_pkg::cdd_byte_t superFineDelay [cdd_pkg::NCH],
    output logic fineEnable,
    output logic superFineEnable,
    output logic fineMode192,
    output logic datapathRst,
    output logic [1:0] dcsEnable
);
    import cdd_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    cdd_cfg_if cfg ();                // link to divider and delay map
    cdd_byte_t ratio_r;               // divider ratio and sync state
    cdd_byte_t half_r;                // half-period delay enables
    cdd_byte_t ctrl_r;                // delay control
    cdd_byte_t fine_r [NCH];          // fine codes per channel
    cdd_byte_t sfine_r [NCH];         // super-fine codes per channel
    cdd_byte_t dcsA_r;                // stabilizer control a
    cdd_byte_t dcsB_r;                // stabilizer control b
    cdd_byte_t rdData_r;              // read answer
    cdd_byte_t rdData_nxt;            // read mux
    logic sysrefPrev_r;               // captured sysref level
    logic sysrefOld_r;                // level one cycle earlier
    logic dpRst_r;                    // datapath reset pulse
    logic rdCh;                       // channel read back
    logic wrCtrl;                     // write strobes
    logic wrFine;
    logic wrSfine;
    logic wrHalf;
    logic wrRatio;

    // ****************************************
    // write decode
    // ****************************************
    assign wrRatio = regWrEn && (regAddr == ADDR_DIV_RATIO);
    assign wrHalf = regWrEn && (regAddr == ADDR_HALF_DLY);
    assign wrCtrl = regWrEn && (regAddr == ADDR_DLY_CTRL);
    assign wrSfine = regWrEn && (regAddr == ADDR_SFINE);
    assign wrFine = regWrEn && (regAddr == ADDR_FINE);

    // ****************************************
    // shared registers
    // ****************************************
    // divider ratio; the host is expected to set it before the clock runs
    always_ff @(posedge clk) begin
        if (rst) begin
            ratio_r <= RST_ZERO;
        end else if (wrRatio) begin
            ratio_r <= regWrData;
        end
    end

    // half-period delay; only the divider phase moves, no reset is raised
    always_ff @(posedge clk) begin
        if (rst) begin
            half_r <= RST_ZERO;
        end else if (wrHalf) begin
            half_r <= regWrData;
        end
    end

    // delay control field
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= RST_ZERO;
        end else if (wrCtrl) begin
            ctrl_r <= regWrData;
        end
    end

    // stabilizer controls; enabled out of reset
    always_ff @(posedge clk) begin
        if (rst) begin
            dcsA_r <= RST_DCS;
            dcsB_r <= RST_DCS;
        end else if (regWrEn) begin
            if (regAddr == ADDR_DCS_A) begin
                dcsA_r <= regWrData;
            end
            if (regAddr == ADDR_DCS_B) begin
                dcsB_r <= regWrData;
            end
        end
    end

    // ****************************************
    // per-channel delay codes
    // ****************************************
    // every selected channel takes the write; rewrites never reset anything
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int ch = 0; ch < NCH; ch++) begin
                fine_r[ch] <= RST_ZERO;
                sfine_r[ch] <= RST_ZERO;
            end
        end else begin
            for (int ch = 0; ch < NCH; ch++) begin
                if (wrFine && chanSel[ch]) begin
                    fine_r[ch] <= regWrData;
                end
                if (wrSfine && chanSel[ch]) begin
                    sfine_r[ch] <= regWrData;
                end
            end
        end
    end

    // ****************************************
    // datapath reset
    // ****************************************
    // only a write that turns fine delay on from off resets the datapath,
    // so retuning an already enabled delay leaves the link alone
    always_ff @(posedge clk) begin
        if (rst) begin
            dpRst_r <= 1'b0;
        end else begin
            dpRst_r <= wrCtrl && (regWrData[2:0] != CTRL_OFF)
                && (ctrl_r[2:0] == CTRL_OFF);
        end
    end

    // ****************************************
    // sysref capture
    // ****************************************
    // a valid event is a rising level; it is applied on the following edge
    always_ff @(posedge clk) begin
        if (rst) begin
            sysrefPrev_r <= 1'b0;
            sysrefOld_r <= 1'b0;
        end else begin
            sysrefPrev_r <= sysrefIn;
            sysrefOld_r <= sysrefPrev_r;
        end
    end

    // ****************************************
    // read back
    // ****************************************
    // lowest selected channel answers; unmapped addresses read zero
    assign rdCh = (NCH > 1) && !chanSel[0] && chanSel[NCH-1];

    always_comb begin
        rdData_nxt = RST_ZERO;
        unique case (regAddr)
            ADDR_DIV_RATIO: rdData_nxt = ratio_r;
            ADDR_HALF_DLY: rdData_nxt = half_r;
            ADDR_DLY_CTRL: rdData_nxt = ctrl_r;
            ADDR_SFINE: rdData_nxt = sfine_r[rdCh];
            ADDR_FINE: rdData_nxt = fine_r[rdCh];
            ADDR_DCS_A: rdData_nxt = dcsA_r;
            ADDR_DCS_B: rdData_nxt = dcsB_r;
            default: rdData_nxt = RST_ZERO;
        endcase
    end

    // answer held until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_r <= RST_ZERO;
        end else if (regRdEn) begin
            rdData_r <= rdData_nxt;
        end
    end

    // ****************************************
    // submodules
    // ****************************************
    assign cfg.ratioCode = ratio_r[RATIO_LSB +: 2];
    assign cfg.syncState = ratio_r[SYNC_LSB +: 3];
    assign cfg.halfDelay = half_r[NCH-1:0];
    assign cfg.sysrefHit = sysrefPrev_r && !sysrefOld_r;
    assign cfg.ctrl = ctrl_r[2:0];
    assign cfg.fineVal = fine_r;
    assign cfg.superVal = sfine_r;

    cdd_divider uDiv (
        .clk(clk),
        .rst(rst),
        .cfg(cfg.div)
    );

    cdd_delay_map uDly (
        .clk(clk),
        .rst(rst),
        .cfg(cfg.dly)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign regRdData = rdData_r;
    assign divClkOut = cfg.divOut;
    assign sampleEn = cfg.sampleEn;
    assign fineDelay = cfg.fineOut;
    assign superFineDelay = cfg.superOut;
    assign fineEnable = cfg.fineEn;
    assign superFineEnable = cfg.superEn;
    assign fineMode192 = cfg.mode192;
    assign datapathRst = dpRst_r;
    assign dcsEnable = {dcsB_r[DCS_EN_BIT], dcsA_r[DCS_EN_BIT]};

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [3:0] quietCnt;   // cycles since last phase disturbance
    logic [3:0] highCnt;    // length of current high phase, channel 0

    // a ratio, half-delay or sysref change resets the quiet window
    always_ff @(posedge clk) begin
        if (rst || wrRatio || wrHalf || cfg.sysrefHit) begin
            quietCnt <= 4'h0;
        end else if (quietCnt != 4'hF) begin
            quietCnt <= quietCnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !divClkOut[0]) begin
            highCnt <= 4'h0;
        end else if (highCnt != 4'hF) begin
            highCnt <= highCnt + 4'h1;
        end
    end

    // ****************************************
    // named steps
    // ****************************************
    sequence sEnableWr;
        wrCtrl && (regWrData[2:0] != CTRL_OFF) && (ctrl_r[2:0] == CTRL_OFF);
    endsequence

    sequence sRstPulse;
        datapathRst ##1 !datapathRst;
    endsequence

    sequence sFineWr;
        wrFine && chanSel[0] && (ctrl_r[2:0] != CTRL_OFF) && !wrCtrl;
    endsequence

    a_duty_half_period: assert property (
        $fell(divClkOut[0]) && (quietCnt == 4'hF)
        |-> ({1'b0, highCnt} == {1'b0, periodOf(ratio_r[RATIO_LSB +: 2]) >> 1}))
        else $error("divided clock high phase is not half the period");

    a_sysref_load: assert property (
        cfg.sysrefHit && !wrRatio
        |=> (cfg.divCnt == (ratio_r[SYNC_LSB +: 3]
            & 3'(periodOf(ratio_r[RATIO_LSB +: 2]) - 4'h1))) && $stable(ratio_r))
        else $error("sysref did not load the divider state");

    // either channel may be the late one; the other is the reference
    a_half_shift: assert property (
        (half_r[0] != half_r[1]) && (quietCnt > 4'h3)
        |-> (half_r[0] ? (divClkOut[0] == $past(divClkOut[1]))
            : (divClkOut[1] == $past(divClkOut[0]))))
        else $error("half-period delay not one cycle behind");

    a_link_quiet: assert property (
        (wrHalf || wrFine || wrSfine) |=> !datapathRst)
        else $error("delay value write reset the datapath");

    a_fine_reset: assert property (
        sEnableWr |=> sRstPulse)
        else $error("enabling fine delay gave no datapath reset");

    a_sf_gate: assert property (
        superFineEnable |-> ($past(ctrl_r[2:0]) == CTRL_SF_A)
            || ($past(ctrl_r[2:0]) == CTRL_SF_B))
        else $error("super-fine active with wrong control value");

    a_delay_clamp: assert property (
        (fineDelay[0] <= (fineMode192 ? FINE_MAX_192 : FINE_MAX_16))
        && (superFineDelay[0] <= SFINE_MAX)
        && (superFineEnable || (superFineDelay[0] == RST_ZERO)))
        else $error("delay code outside its step range");

    a_delay_now: assert property (
        sFineWr ##1 !wrCtrl
        |-> ##1 fineDelay[0] == clampTo($past(regWrData, 2),
            fineMode192 ? FINE_MAX_192 : FINE_MAX_16))
        else $error("fine delay not applied after the write");

    a_dcs_default: assert property (
        $past(rst) |-> (dcsEnable == 2'b11))
        else $error("stabilizer not enabled after reset");

    a_sysref_single: assert property (
        cfg.sysrefHit |=> !cfg.sysrefHit)
        else $error("one sysref level gave two events");

    a_dcs_write: assert property (
        regWrEn && (regAddr == ADDR_DCS_A)
        |=> dcsEnable[0] == $past(regWrData[DCS_EN_BIT]))
        else $error("stabilizer enable a not taken from the write");

    a_dp_cause: assert property (
        datapathRst |-> $past(wrCtrl) && ($past(ctrl_r[2:0]) == CTRL_OFF))
        else $error("datapath reset without a delay turn-on write");
endmodule

// *** rtl/cdd_delay_map.sv ***
/*
 maps the delay control field and raw codes onto applied fine and super-fine
 delay codes. assumes codes come straight from the register file.
*/
`timescale 1ns/10ps
module cdd_delay_map (
    input wire logic clk,
    input wire logic rst,
    cdd_cfg_if.dly cfg
);
    import cdd_pkg::*;
    logic sfOn;   // super-fine selected
    logic fnOn;   // fine selected

    assign sfOn = (cfg.ctrl == CTRL_SF_A) || (cfg.ctrl == CTRL_SF_B);
    assign fnOn = (cfg.ctrl != CTRL_OFF);

    // registered so the analog delay line sees clean codes
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg.fineEn <= 1'b0;
            cfg.superEn <= 1'b0;
            cfg.mode192 <= 1'b0;
            for (int ch = 0; ch < NCH; ch++) begin
                cfg.fineOut[ch] <= RST_ZERO;
                cfg.superOut[ch] <= RST_ZERO;
            end
        end else begin
            cfg.fineEn <= fnOn;
            cfg.superEn <= sfOn;
            cfg.mode192 <= cfg.ctrl[MODE192_BIT];
            for (int ch = 0; ch < NCH; ch++) begin
                // out-of-range codes saturate at the last step
                cfg.fineOut[ch] <= !fnOn ? RST_ZERO : clampTo(cfg.fineVal[ch],
                    cfg.ctrl[MODE192_BIT] ? FINE_MAX_192 : FINE_MAX_16);
                cfg.superOut[ch] <= sfOn ? clampTo(cfg.superVal[ch], SFINE_MAX)
                    : RST_ZERO;
            end
        end
    end
endmodule

// *** rtl/cdd_divider.sv ***
/*
 input clock divider: /1, /2 or /4 with 50% duty, sysref realignment and a
 per-channel half-period delay. assumes clk ticks once per half input period.
*/
`timescale 1ns/10ps
module cdd_divider (
    input wire logic clk,
    input wire logic rst,
    cdd_cfg_if.div cfg
);
    import cdd_pkg::*;
    logic [3:0] period;     // cycles per divided period
    logic baseOut;          // undelayed divided clock
    logic baseEn;           // undelayed period start
    logic [NCH-1:0] outD_r; // one-cycle delayed copies
    logic [NCH-1:0] enD_r;

    assign period = periodOf(cfg.ratioCode);
    // high for exactly the first half of the period, so duty stays 50%
    assign baseOut = ({1'b0, cfg.divCnt} < (period >> 1));
    assign baseEn = (cfg.divCnt == 3'h0);

    // counter: sysref loads the programmed state, ratio left alone
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg.divCnt <= 3'h0;
        end else if (cfg.sysrefHit) begin
            cfg.divCnt <= cfg.syncState & 3'(period - 4'h1);
        end else if ({1'b0, cfg.divCnt} >= period - 4'h1) begin
            cfg.divCnt <= 3'h0;
        end else begin
            cfg.divCnt <= cfg.divCnt + 3'h1;
        end
    end

    // per channel: pick plain or half-period delayed phase
    always_ff @(posedge clk) begin
        if (rst) begin
            outD_r <= '0;
            enD_r <= '0;
            cfg.divOut <= '0;
            cfg.sampleEn <= '0;
        end else begin
            for (int ch = 0; ch < NCH; ch++) begin
                outD_r[ch] <= baseOut;
                enD_r[ch] <= baseEn;
                cfg.divOut[ch] <= cfg.halfDelay[ch] ? outD_r[ch] : baseOut;
                cfg.sampleEn[ch] <= cfg.halfDelay[ch] ? enD_r[ch] : baseEn;
            end
        end
    end
endmodule

// *** rtl/cdd_pkg.sv ***
/*
 package for the sample clock divider and delay control block: register
 offsets, field layout, reset values and shared helper functions.
 assumes one clock in which one cycle is half an input clock period.
*/
package cdd_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NCH = 2;               // channels with own delay state
    typedef logic [15:0] cdd_addr_t;      // register address
    typedef logic [7:0] cdd_byte_t;       // register data
    // ****************************************
    // register offsets
    // ****************************************
    localparam cdd_addr_t ADDR_DIV_RATIO = 16'h0108;
    localparam cdd_addr_t ADDR_HALF_DLY = 16'h0109;
    localparam cdd_addr_t ADDR_DLY_CTRL = 16'h0110;
    localparam cdd_addr_t ADDR_SFINE = 16'h0111;
    localparam cdd_addr_t ADDR_FINE = 16'h0112;
    localparam cdd_addr_t ADDR_DCS_A = 16'h011C;
    localparam cdd_addr_t ADDR_DCS_B = 16'h011E;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int RATIO_LSB = 0;         // divider ratio code, 2 bits
    localparam int SYNC_LSB = 4;          // divider state loaded on sysref, 3 bits
    localparam int MODE192_BIT = 2;       // fine delay step option
    localparam int DCS_EN_BIT = 0;        // stabilizer enable
    localparam cdd_byte_t RST_ZERO = 8'h00;
    localparam cdd_byte_t RST_DCS = 8'h01;
    localparam logic [2:0] CTRL_OFF = 3'h0;
    localparam logic [2:0] CTRL_SF_A = 3'h2;
    localparam logic [2:0] CTRL_SF_B = 3'h6;
    // ratio codes
    typedef enum logic [1:0] {
        CDD_DIV1 = 2'h0,
        CDD_DIV2 = 2'h1,
        CDD_DIV4 = 2'h2
    } cdd_ratio_t;
    // ****************************************
    // step counts
    // ****************************************
    localparam cdd_byte_t FINE_MAX_16 = 8'h0F;   // 16 steps
    localparam cdd_byte_t FINE_MAX_192 = 8'hBF;  // 192 steps
    localparam cdd_byte_t SFINE_MAX = 8'h7F;     // 128 steps
    localparam int SFINE_STEP_FS = 250;          // 0.25 ps per super-fine step
    // divider period in half input periods (clk cycles)
    function automatic logic [3:0] periodOf(input logic [1:0] code);
        unique case (code)
            CDD_DIV2: periodOf = 4'h4;
            CDD_DIV4: periodOf = 4'h8;
            default: periodOf = 4'h2;
        endcase
    endfunction
    // saturate a delay code at its last step
    function automatic cdd_byte_t clampTo(input cdd_byte_t v, input cdd_byte_t m);
        clampTo = (v > m) ? m : v;
    endfunction
endpackage

// *** sim/cdd_clock_ctrl_tb.sv ***
/*
 self-checking bench for the clock divider and delay control top.
 assumes inputs change on the falling edge and outputs settle by then.
*/
`timescale 1ns/10ps
module cdd_clock_ctrl_tb;
    import cdd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fire = 1'b0;  // asks the partner for a sysref event
    logic sysrefIn;
    logic [NCH-1:0] chanSel = 2'h1;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    cdd_addr_t regAddr = 16'h0000;
    cdd_byte_t regWrData = 8'h00;
    cdd_byte_t regRdData;
    logic [NCH-1:0] divClkOut;
    logic [NCH-1:0] sampleEn;
    cdd_byte_t fineDelay [NCH];
    cdd_byte_t superFineDelay [NCH];
    logic fineEnable;
    logic superFineEnable;
    logic fineMode192;
    logic datapathRst;
    logic [1:0] dcsEnable;
    int fails = 0;
    int totalChecks = 0;
    cdd_byte_t rdExp [$];  // expected read answers, oldest first
    logic rdPend = 1'b0;   // a read was taken at the last rising edge
    always #20 clk = ~clk;
    cdd_clock_ctrl cdd_clock_ctrl_i (.clk(clk), .rst(rst), .sysrefIn(sysrefIn),
        .chanSel(chanSel), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .divClkOut(divClkOut),
        .sampleEn(sampleEn), .fineDelay(fineDelay), .superFineDelay(superFineDelay),
        .fineEnable(fineEnable), .superFineEnable(superFineEnable),
        .fineMode192(fineMode192), .datapathRst(datapathRst), .dcsEnable(dcsEnable));
    cdd_sysref_src cdd_sysref_src_i (.clk(clk), .fire(fire), .sysrefIn(sysrefIn));
    // ****************************************
    // reporting
    // ****************************************
    task automatic completeRun();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ****************************************
    // register port and waits
    // ****************************************
    task automatic wr(input cdd_addr_t a, input cdd_byte_t d, input logic [1:0] cs);
        @(negedge clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        chanSel = cs;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    // the expected answer is noted now and compared when it appears
    task automatic rd(input cdd_addr_t a, input cdd_byte_t e);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        rdExp.push_back(e);
        @(negedge clk);
        regRdEn = 1'b0;
    endtask
    // bounded wait for a sample pulse on one channel
    task automatic waitSe(input int ch);
        int n = 0;
        while (sampleEn[ch] !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 40) begin
                fails++;
                $display("[FAIL] sampleEn expected 1 seen none");
                completeRun();
            end
        end
    endtask
    // read answer is checked at the falling edge just after the taking edge
    always @(posedge clk) begin
        rdPend <= regRdEn;
    end
    always @(negedge clk) begin
        if (rdPend) begin
            chk("regRdData", rdExp.pop_front(), regRdData);
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        cdd_addr_t aT [8] = '{ADDR_DIV_RATIO, ADDR_HALF_DLY, ADDR_DLY_CTRL, ADDR_SFINE,
            ADDR_FINE, ADDR_DCS_A, ADDR_DCS_B, 16'h0100};
        int s;
        int per;
        int hi;
        logic [2:0] c;
        cdd_byte_t fv;
        cdd_byte_t sv;
        cdd_byte_t fe;
        cdd_byte_t se;
        void'($urandom(28));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk("dcsEnable", 8'h03, {6'h00, dcsEnable});
        foreach (aT[i]) begin
            rd(aT[i], (i == 5 || i == 6) ? RST_DCS : RST_ZERO);
        end
        wr(16'h0101, 8'hFF, 2'h1);
        rd(16'h0101, 8'h00);
        wr(ADDR_DCS_A, 8'h00, 2'h1);
        @(negedge clk);
        chk("dcsEnable", 8'h02, {6'h00, dcsEnable});
        wr(ADDR_DCS_B, 8'h00, 2'h1);
        @(negedge clk);
        chk("dcsEnable", 8'h00, {6'h00, dcsEnable});
        // period and high time for every ratio code, 3 behaves as /1
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_DIV_RATIO, 8'(r), 2'h1);
            repeat (10) @(negedge clk);
            waitSe(0);
            per = 0;
            hi = 0;
            do begin
                hi += int'(divClkOut[0] === 1'b1);
                per++;
                @(negedge clk);
            end while (sampleEn[0] !== 1'b1 && per < 20);
            chk("period", 8'(r == 1 ? 4 : r == 2 ? 8 : 2), 8'(per));
            chk("high time", 8'(r == 1 ? 2 : r == 2 ? 4 : 1), 8'(hi));
        end
        // channel 0 half-period late against channel 1
        wr(ADDR_HALF_DLY, 8'h01, 2'h1);
        chk("datapathRst", 8'h00, {7'h00, datapathRst});
        repeat (10) @(negedge clk);
        waitSe(1);
        @(negedge clk);
        chk("late sampleEn", 8'h01, {7'h00, sampleEn[0]});
        wr(ADDR_HALF_DLY, 8'h00, 2'h1);
        // sysref loads a random divider state, ratio kept
        s = $urandom_range(7);
        wr(ADDR_DIV_RATIO, {1'b0, 3'(s), 4'h2}, 2'h1);
        @(negedge clk);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        @(posedge clk);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("aligned divClkOut", 8'(s < 4), {7'h00, divClkOut[0]});
        chk("aligned sampleEn", 8'(s == 0), {7'h00, sampleEn[0]});
        rd(ADDR_DIV_RATIO, {1'b0, 3'(s), 4'h2});
        // every delay control code from the off state
        fv = 8'($urandom_range(255));
        sv = 8'($urandom_range(255));
        wr(ADDR_FINE, fv, 2'h1);
        wr(ADDR_SFINE, sv, 2'h1);
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            fe = (c == 3'h0) ? 8'h00 : (c[2] ? 8'hBF : 8'h0F);
            fe = (fv < fe) ? fv : fe;
            se = (c == 3'h2 || c == 3'h6) ? ((sv > 8'h7F) ? 8'h7F : sv) : 8'h00;
            wr(ADDR_DLY_CTRL, 8'h00, 2'h1);
            wr(ADDR_DLY_CTRL, {5'h00, c}, 2'h1);
            chk("datapathRst", 8'(c != 3'h0), {7'h00, datapathRst});
            @(negedge clk);
            chk("fineEnable", 8'(c != 3'h0), {7'h00, fineEnable});
            chk("superFineEnable", 8'(se != 8'h00 || c == 3'h2 || c == 3'h6),
                {7'h00, superFineEnable});
            chk("fineMode192", {7'h00, c[2] & (c != 3'h0)}, {7'h00, fineMode192});
            chk("fineDelay", fe, fineDelay[0]);
            chk("superFineDelay", se, superFineDelay[0]);
        end
        // value rewrites on channels 1 and 0 apply at once; channel 1 rewrites reset nothing
        fv = 8'($urandom_range(255));
        wr(ADDR_FINE, fv, 2'h2);
        chk("datapathRst", 8'h00, {7'h00, datapathRst});
        @(negedge clk);
        chk("fineDelay ch1", (fv > 8'hBF) ? 8'hBF : fv, fineDelay[1]);
        chk("fineDelay ch0", fe, fineDelay[0]);
        rd(ADDR_FINE, fv);
        wr(ADDR_FINE, ~fv, 2'h1);
        @(negedge clk);
        chk("fineDelay ch0", (~fv > 8'hBF) ? 8'hBF : ~fv, fineDelay[0]);
        wr(ADDR_DLY_CTRL, 8'h06, 2'h2);
        sv = 8'hFF;
        wr(ADDR_SFINE, sv, 2'h2);
        chk("datapathRst", 8'h00, {7'h00, datapathRst});
        @(negedge clk);
        chk("superFineDelay ch1", 8'h7F, superFineDelay[1]);
        repeat (4) @(negedge clk);
        completeRun();
    end
endmodule

// *** sim/cdd_sysref_src.sv ***
/*
 partner model: the sysref source that re-aligns the sample clock divider.
 assumes the bench asks for an event by a one-cycle fire pulse.
*/
`timescale 1ns/10ps
module cdd_sysref_src #(
    parameter int HOLD = 4  // cycles the level stays high
) (
    input wire logic clk,
    input wire logic fire,
    output logic sysrefIn = 1'b0
);
    logic armed = 1'b0;  // request seen at the rising edge
    int cnt = 0;         // high cycles left
    // ****************************************
    // level generator
    // ****************************************
    always @(posedge clk) begin
        armed <= fire;
    end
    // the level is held for several samples on purpose: only one event may follow
    always @(negedge clk) begin
        if (armed) begin
            cnt = HOLD;
        end
        sysrefIn <= (cnt != 0);
        if (cnt != 0) begin
            cnt = cnt - 1;
        end
    end
endmodule
